// ### rtl/vss_sequencer.sv
// Start-up sequencer and voltage-code decoder for a multiphase regulator
// Summary of operation
// - Phase outputs stay high-impedance (enables low) throughout shutdown.
// - Leave shutdown only with power-on-reset good and both enables high.
// - Wait the fixed start-up delay before the first reference ramp.
// - Ramps move the reference one 6.25 mV step; first ramp ends at 1.1 V.
// - Each ramp step is taken on one soft-start oscillator period.
// - Hold boot level 85 us, then sample code as soon as it is valid.
// - A code is valid once unchanged for at least 500 ns; a code already valid is sampled at once.
// - A valid sampled code starts the second ramp to code minus offset.
// - An OFF code shuts down until supply or an enable is cycled.
// - Code 0x8E is 0.725 V, each increment one step lower; 0xFE, 0xFF are OFF.
// - Ready rises a fixed delay after reaching the final coded setting.
// - Ready is low in shutdown and on any disable or OFF code.
`timescale 1ns/1ps
module vss_sequencer #(
    parameter int unsigned PHASES = 6,
    parameter int unsigned STARTUP_CYC = vss_pkg::STARTUP_DELAY_CYC,
    parameter int unsigned BOOT_HOLD_CYC = vss_pkg::BOOT_HOLD_TIME_CYC,
    parameter int unsigned VALID_CYC = vss_pkg::CODE_VALID_MIN_CYC,
    parameter int unsigned READY_CYC = vss_pkg::READY_DELAY_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_por_ok,
    input wire logic i_power_enable_in,
    input wire logic i_tracking_rail_enable_in,
    input wire logic i_ss_osc,
    input wire logic [7:0] i_voltage_code,
    input wire logic [8:0] i_offset_steps,
    output logic [PHASES-1:0] o_pwm_oe,
    output logic [8:0] o_dac_ref,
    output logic o_regulator_ready_out,
    output logic o_regulator_ready_oe,
    output logic o_shutdown,
    output logic o_off_latched
);
    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    localparam int CNT_W = 20;
    logic [2:0] en_sync;
    logic [7:0] code_sync;
    logic osc_sync;
    logic osc_prev_r;
    logic osc_tick;
    logic all_enabled;

    vss_sync #(.WIDTH(4)) u_sync_en (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_async({i_ss_osc, i_por_ok, i_power_enable_in, i_tracking_rail_enable_in}),
        .o_sync({osc_sync, en_sync})
    );

    vss_sync #(.WIDTH(8)) u_sync_code (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_async(i_voltage_code),
        .o_sync(code_sync)
    );

    assign all_enabled = &en_sync;
    assign osc_tick = osc_sync && !osc_prev_r;

    // ------------------------------------------------------------
    // Code decoding
    // ------------------------------------------------------------
    function automatic logic code_is_off(input logic [7:0] code);
        code_is_off = (code == vss_pkg::CODE_OFF_A) || (code == vss_pkg::CODE_OFF_B);
    endfunction : code_is_off

    function automatic logic [8:0] code_level(input logic [7:0] code,
                                              input logic [8:0] ofs);
        logic [9:0] lvl;
        lvl = {1'b0, vss_pkg::CODE_LAW_BASE} - {2'b00, code};
        if (lvl[8:0] > ofs)
        begin
            code_level = lvl[8:0] - ofs;
        end
        else
        begin
            code_level = vss_pkg::REF_ZERO;
        end
    endfunction : code_level

    function automatic logic [8:0] step_toward(input logic [8:0] cur,
                                               input logic [8:0] tgt);
        if (cur < tgt)
        begin
            step_toward = cur + 9'h001;
        end
        else if (cur > tgt)
        begin
            step_toward = cur - 9'h001;
        end
        else
        begin
            step_toward = cur;
        end
    endfunction : step_toward

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    vss_pkg::vss_state_t state_r;
    vss_pkg::vss_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] valid_cnt_r;
    logic [CNT_W-1:0] valid_cnt_nxt;
    logic [7:0] stable_code_r;
    logic [7:0] stable_code_nxt;
    logic [8:0] ref_r;
    logic [8:0] ref_nxt;
    logic [8:0] target_r;
    logic [8:0] target_nxt;
    logic ready_r;
    logic ready_nxt;
    logic code_valid;
    logic shutdown_r;
    logic shutdown_nxt;
    logic off_r;
    logic off_nxt;
    logic [PHASES-1:0] pwm_oe_r;
    logic [PHASES-1:0] pwm_oe_nxt;
    logic pull_low_r;
    logic pull_low_nxt;

    assign code_valid = (valid_cnt_r >= CNT_W'(VALID_CYC));

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ref_nxt = ref_r;
        target_nxt = target_r;
        ready_nxt = 1'b0;
        stable_code_nxt = code_sync;
        valid_cnt_nxt = valid_cnt_r;
        // Code must stay unchanged for the validation time
        if (code_sync != stable_code_r)
        begin
            valid_cnt_nxt = '0;
        end
        else if (!code_valid)
        begin
            valid_cnt_nxt = valid_cnt_r + CNT_W'(1);
        end
        unique case (state_r)
            vss_pkg::VSS_SHUTDOWN:
            begin
                ref_nxt = vss_pkg::REF_ZERO;
                cnt_nxt = '0;
                if (all_enabled)
                begin
                    state_nxt = vss_pkg::VSS_START_WAIT;
                end
            end
            vss_pkg::VSS_START_WAIT:
            begin
                cnt_nxt = cnt_r + CNT_W'(1);
                if (cnt_r >= CNT_W'(STARTUP_CYC - 1))
                begin
                    cnt_nxt = '0;
                    state_nxt = vss_pkg::VSS_RAMP_BOOT;
                end
            end
            vss_pkg::VSS_RAMP_BOOT:
            begin
                if (osc_tick)
                begin
                    ref_nxt = step_toward(ref_r, vss_pkg::BOOT_LEVEL);
                end
                if (ref_r == vss_pkg::BOOT_LEVEL)
                begin
                    cnt_nxt = '0;
                    state_nxt = vss_pkg::VSS_BOOT_HOLD;
                end
            end
            vss_pkg::VSS_BOOT_HOLD:
            begin
                if (cnt_r < CNT_W'(BOOT_HOLD_CYC))
                begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
                else if (code_valid)
                begin
                    cnt_nxt = '0;
                    if (code_is_off(stable_code_r))
                    begin
                        state_nxt = vss_pkg::VSS_OFF_LATCHED;
                    end
                    else
                    begin
                        target_nxt = code_level(stable_code_r, i_offset_steps);
                        state_nxt = vss_pkg::VSS_RAMP_TARGET;
                    end
                end
            end
            vss_pkg::VSS_RAMP_TARGET:
            begin
                if (osc_tick)
                begin
                    ref_nxt = step_toward(ref_r, target_r);
                end
                if (ref_r == target_r)
                begin
                    cnt_nxt = '0;
                    state_nxt = vss_pkg::VSS_READY_WAIT;
                end
            end
            vss_pkg::VSS_READY_WAIT:
            begin
                cnt_nxt = cnt_r + CNT_W'(1);
                if (cnt_r >= CNT_W'(READY_CYC - 1))
                begin
                    state_nxt = vss_pkg::VSS_REGULATE;
                end
            end
            vss_pkg::VSS_REGULATE:
            begin
                ready_nxt = 1'b1;
                if (code_valid && code_is_off(stable_code_r))
                begin
                    ready_nxt = 1'b0;
                    state_nxt = vss_pkg::VSS_OFF_LATCHED;
                end
                else if (code_valid)
                begin
                    target_nxt = code_level(stable_code_r, i_offset_steps);
                    if (osc_tick)
                    begin
                        ref_nxt = step_toward(ref_r, target_r);
                    end
                end
            end
            vss_pkg::VSS_OFF_LATCHED:
            begin
                ref_nxt = vss_pkg::REF_ZERO;
                cnt_nxt = '0;
            end
        endcase
        // Any dropped enable returns to shutdown; this also releases OFF
        if (!all_enabled)
        begin
            state_nxt = vss_pkg::VSS_SHUTDOWN;
            ready_nxt = 1'b0;
            ref_nxt = vss_pkg::REF_ZERO;
            cnt_nxt = '0;
        end
        // Status outputs registered alongside the state
        shutdown_nxt = (state_nxt == vss_pkg::VSS_SHUTDOWN)
                       || (state_nxt == vss_pkg::VSS_OFF_LATCHED);
        off_nxt = (state_nxt == vss_pkg::VSS_OFF_LATCHED);
        pwm_oe_nxt = shutdown_nxt ? '0 : '1;
        pull_low_nxt = !ready_nxt;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            state_r <= vss_pkg::VSS_SHUTDOWN;
            cnt_r <= '0;
            valid_cnt_r <= '0;
            stable_code_r <= '0;
            ref_r <= vss_pkg::REF_ZERO;
            target_r <= vss_pkg::REF_ZERO;
            ready_r <= 1'b0;
            osc_prev_r <= 1'b0;
            shutdown_r <= 1'b1;
            off_r <= 1'b0;
            pwm_oe_r <= '0;
            pull_low_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            valid_cnt_r <= valid_cnt_nxt;
            stable_code_r <= stable_code_nxt;
            ref_r <= ref_nxt;
            target_r <= target_nxt;
            ready_r <= ready_nxt;
            osc_prev_r <= osc_sync;
            shutdown_r <= shutdown_nxt;
            off_r <= off_nxt;
            pwm_oe_r <= pwm_oe_nxt;
            pull_low_r <= pull_low_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_pwm_oe = pwm_oe_r;
    assign o_dac_ref = ref_r;
    // Open-drain ready: pull low when not ready
    assign o_regulator_ready_out = 1'b0;
    assign o_regulator_ready_oe = pull_low_r;
    assign o_shutdown = shutdown_r;
    assign o_off_latched = off_r;
endmodule : vss_sequencer

// ### rtl/vss_pkg.sv
// Constants for the soft-start sequencer and voltage-code decoder
package vss_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned STARTUP_DELAY_NS = 1360000;
    localparam int unsigned BOOT_HOLD_TIME_NS = 85000;
    localparam int unsigned CODE_VALID_MIN_NS = 500;
    localparam int unsigned READY_DELAY_NS = 85000;
    localparam int unsigned STARTUP_DELAY_CYC = (STARTUP_DELAY_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned BOOT_HOLD_TIME_CYC = (BOOT_HOLD_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CODE_VALID_MIN_CYC =
        (CODE_VALID_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned READY_DELAY_CYC = (READY_DELAY_NS * 1000) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // Reference scale: one step is 6.25 mV, level 0 is 0 V
    // ------------------------------------------------------------
    localparam int REF_W = 9;
    localparam logic [8:0] REF_ZERO = 9'h000;
    localparam logic [8:0] BOOT_LEVEL = 9'h0B0;
    // Linear law: level = 258 - code (1.6125 V / 6.25 mV = 258)
    localparam logic [8:0] CODE_LAW_BASE = 9'h102;
    localparam logic [7:0] CODE_OFF_A = 8'hFE;
    localparam logic [7:0] CODE_OFF_B = 8'hFF;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        VSS_SHUTDOWN,
        VSS_START_WAIT,
        VSS_RAMP_BOOT,
        VSS_BOOT_HOLD,
        VSS_RAMP_TARGET,
        VSS_READY_WAIT,
        VSS_REGULATE,
        VSS_OFF_LATCHED
    } vss_state_t;
endpackage : vss_pkg

// ### rtl/vss_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module vss_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    always_comb
    begin
        out_nxt = out_r;
        for (int b = 0; b < WIDTH; b++)
        begin
            if (s2_r[b] == s3_r[b])
            begin
                out_nxt[b] = s2_r[b];
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end
        else
        begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign o_sync = out_r;
endmodule : vss_sync

// ### testbench/vss_sequencer_properties.sv
// Port checks for the soft-start sequencer
`timescale 1ns/1ps
module vss_sequencer_properties #(
    parameter int unsigned PHASES = 6,
    parameter int unsigned STARTUP_CYC = vss_pkg::STARTUP_DELAY_CYC,
    parameter int unsigned BOOT_HOLD_CYC = vss_pkg::BOOT_HOLD_TIME_CYC,
    parameter int unsigned READY_CYC = vss_pkg::READY_DELAY_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_por_ok,
    input wire logic i_power_enable_in,
    input wire logic i_tracking_rail_enable_in,
    input wire logic [PHASES-1:0] o_pwm_oe,
    input wire logic [8:0] o_dac_ref,
    input wire logic o_regulator_ready_out,
    input wire logic o_regulator_ready_oe,
    input wire logic o_shutdown,
    input wire logic o_off_latched
);
    logic [8:0] ref_q_r;
    int unsigned hold_r;
    int unsigned run_r;
    logic all_en;
    assign all_en = i_por_ok && i_power_enable_in && i_tracking_rail_enable_in;
    // -------------------------------------------------------------
    // Cycles the reference has stood still, cycles out of shutdown
    // -------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        ref_q_r <= o_dac_ref;
        hold_r <= (!i_rst_b || o_dac_ref != ref_q_r) ? 0 : hold_r + 1;
        run_r <= (!i_rst_b || o_shutdown) ? 0 : run_r + 1;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    a_hiz_shutdown: assert property (o_shutdown |-> o_pwm_oe == '0)
        else $error("phase drive on in shutdown");
    a_drive_when_on: assert property (!o_shutdown |-> &o_pwm_oe)
        else $error("phase drive off while running");
    a_ready_low_sd: assert property (o_shutdown |-> o_regulator_ready_oe)
        else $error("ready released in shutdown");
    a_ready_data_low: assert property (o_regulator_ready_out == 1'b0)
        else $error("ready data not low");
    a_ref_one_step: assert property (!o_shutdown && !$past(o_shutdown)
        && o_dac_ref != $past(o_dac_ref) |-> o_dac_ref - $past(o_dac_ref) == 9'h001
        || $past(o_dac_ref) - o_dac_ref == 9'h001) else $error("reference jumped");
    a_disable_off: assert property (!all_en [*8] |-> o_shutdown)
        else $error("running without enables");
    a_off_is_sd: assert property (o_off_latched |-> o_shutdown)
        else $error("off latch without shutdown");
    a_off_holds: assert property ((o_off_latched && all_en) [*8] |=> o_off_latched)
        else $error("off latch cleared early");
    a_start_still: assert property (!o_shutdown && o_dac_ref != ref_q_r
        |-> run_r >= STARTUP_CYC) else $error("ramp before start delay");
    a_boot_hold: assert property (!o_shutdown && o_regulator_ready_oe
        && ref_q_r == vss_pkg::BOOT_LEVEL && o_dac_ref != ref_q_r
        |-> hold_r + 1 >= BOOT_HOLD_CYC) else $error("boot hold too short");
    a_ready_delay: assert property ($fell(o_regulator_ready_oe)
        |-> hold_r + 1 >= READY_CYC) else $error("ready released early");
    c_ready: cover property ($fell(o_regulator_ready_oe));
    c_off: cover property ($rose(o_off_latched));
    c_start: cover property ($fell(o_shutdown));
endmodule : vss_sequencer_properties

// ### testbench/vss_host_model.sv
// Host model presenting the voltage code
`timescale 1ns/1ps
module vss_host_model (
    input wire logic i_mclk,
    input wire logic i_load,
    input wire logic [7:0] i_target,
    output logic [7:0] o_voltage_code
);
    int cnt = 0;
    initial o_voltage_code = 8'h00;
    // Jump on load, else one code step per interval
    always @(posedge i_mclk)
    begin
        cnt <= (cnt == 63) ? 0 : cnt + 1;
        if (i_load)
            o_voltage_code <= i_target;
        else if (cnt == 63 && o_voltage_code != i_target)
            o_voltage_code <= (o_voltage_code < i_target) ?
                o_voltage_code + 8'h01 : o_voltage_code - 8'h01;
    end
endmodule : vss_host_model

// ### testbench/vss_sequencer_bench.sv
// Self-checking bench for the soft-start sequencer
`timescale 1ns/1ps
module vss_sequencer_bench;
    logic i_mclk, i_rst_b, i_por_ok, i_power_enable_in, i_tracking_rail_enable_in;
    logic i_ss_osc, ld, o_regulator_ready_out, o_regulator_ready_oe, o_shutdown, o_off_latched;
    logic [7:0] code, tgt;
    logic [8:0] i_offset_steps, o_dac_ref;
    logic [5:0] o_pwm_oe;
    logic [31:0] seed = 32'h0000_e2c5;
    int n_fail = 0, total_checks = 0, osc_half = 4;
    vss_sequencer #(.PHASES(6), .STARTUP_CYC(50), .BOOT_HOLD_CYC(20), .VALID_CYC(4),
        .READY_CYC(20)) dut (.i_mclk, .i_rst_b, .i_por_ok, .i_power_enable_in,
        .i_tracking_rail_enable_in, .i_ss_osc, .i_voltage_code(code), .i_offset_steps,
        .o_pwm_oe, .o_dac_ref, .o_regulator_ready_out, .o_regulator_ready_oe, .o_shutdown,
        .o_off_latched);
    vss_host_model host (.i_mclk, .i_load(ld), .i_target(tgt), .o_voltage_code(code));
    initial
    begin
        i_mclk = 0;
        forever #2 i_mclk = ~i_mclk;
    end
    // Soft-start oscillator with a runtime rate
    initial
    begin
        i_ss_osc = 0;
        forever
        begin
            repeat (osc_half) @(negedge i_mclk);
            i_ss_osc = ~i_ss_osc;
        end
    end
    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [8:0] lvl(input logic [7:0] c, input logic [8:0] o);
        int v;
        v = int'(vss_pkg::CODE_LAW_BASE) - int'(c) - int'(o);
        return (v < 0) ? 9'h000 : 9'(v);
    endfunction : lvl
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wt(input int s, input logic [8:0] v);
        int n;
        n = 0;
        while (n < 30000 && !(s == 0 ? o_dac_ref === v : s == 1 ? o_regulator_ready_oe
            === v[0] : s == 2 ? o_off_latched === v[0] : o_shutdown === v[0]))
        begin
            @(negedge i_mclk);
            n++;
        end
        if (n >= 30000)
        begin
            chk("wait", v, 9'h1ff);
            finish_test();
        end
    endtask : wt
    task automatic en(input logic [2:0] b);
        {i_por_ok, i_power_enable_in, i_tracking_rail_enable_in} = b;
        repeat (2) @(negedge i_mclk);
    endtask : en
    task automatic load(input logic [7:0] c);
        tgt = c;
        ld = 1;
        repeat (2) @(negedge i_mclk);
        ld = 0;
    endtask : load
    task automatic run(input logic [7:0] c, input logic [8:0] o);
        i_offset_steps = o;
        load(c);
        en(3'b111);
        wt(3, 9'h000);
        repeat (40) @(negedge i_mclk);
        chk("ref_start", vss_pkg::REF_ZERO, o_dac_ref);
        chk("pwm_on", 9'h03f, {3'h0, o_pwm_oe});
        wt(0, vss_pkg::BOOT_LEVEL);
        wt(0, lvl(c, o));
        chk("ready_early", 9'h001, {8'h00, o_regulator_ready_oe});
        wt(1, 9'h000);
        tgt = (c > 8'h03) ? c - 8'h03 : c + 8'h03;
        wt(0, lvl(tgt, o));
        i_tracking_rail_enable_in = 0;
        wt(3, 9'h001);
        chk("ready_sd", 9'h001, {8'h00, o_regulator_ready_oe});
        en(3'b000);
    endtask : run
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    initial
    begin
        {i_rst_b, i_por_ok, i_power_enable_in, i_tracking_rail_enable_in, ld} = 5'h00;
        tgt = 8'h00;
        i_offset_steps = 9'h000;
        repeat (10) @(negedge i_mclk);
        i_rst_b = 1;
        @(negedge i_mclk);
        chk("reset", 9'h140, {o_shutdown, o_off_latched, o_regulator_ready_oe, o_pwm_oe});
        load(8'h8e);
        for (int k = 0; k < 3; k++)
        begin
            en(3'b111 ^ (3'b001 << k));
            repeat (200) @(negedge i_mclk);
            chk("still_sd", 9'h001, {8'h00, o_shutdown});
        end
        for (int k = 0; k < 2; k++)
        begin
            load(k ? 8'hff : 8'hfe);
            en(3'b111);
            wt(2, 9'h001);
            load(8'h8e);
            repeat (300) @(negedge i_mclk);
            chk("off_held", 9'h003, {7'h00, o_off_latched, o_regulator_ready_oe});
            en(3'b000);
        end
        run(8'h8e, 9'h000);
        run(8'hb2, 9'h000);
        run(8'h1e, 9'h004);
        for (int k = 0; k < 3; k++)
        begin
            osc_half = 2 + int'(rnd() % 6);
            run(8'(rnd() % 254), 9'(rnd() % 16));
        end
        finish_test();
    end
endmodule : vss_sequencer_bench
bind vss_sequencer vss_sequencer_properties #(.PHASES(PHASES), .STARTUP_CYC(STARTUP_CYC),
    .BOOT_HOLD_CYC(BOOT_HOLD_CYC), .READY_CYC(READY_CYC)) u_props (.i_mclk, .i_rst_b,
    .i_por_ok, .i_power_enable_in,
    .i_tracking_rail_enable_in, .o_pwm_oe, .o_dac_ref, .o_regulator_ready_out,
    .o_regulator_ready_oe, .o_shutdown, .o_off_latched);
